// [logic/efc_ctrl.sv]
// Notes on behaviour
// - Select high sends read FIFO data to system side, else output latch data.
// - Memory clock rise with read push enable low pushes memory word.
// - System clock edge with read pop enable low pops read FIFO.
// - Memory clock rise with write pop enable low pops write FIFO toward memory.
// - System clock edge with write push enable low stores system data word.
// - Check-bit driver enabled by force input, else by memory output enable.
// - Mode load low at system clock edge loads data bits 0 to 15.
// - Each error at diagnostic clock rise counts up, saturating at 15.
// - First error after diagnostic reset captures check bits, syndrome, type, data.
// - Running syndrome register loads on every diagnostic clock rise.
// - Write FIFO empty flag low when empty, low after reset.
// - Write FIFO full flag low when full, high after reset.
// - Read FIFO empty flag low when empty, low after reset.
// - Read FIFO full flag low when full, high after reset.
// - Half flag low at eight or more words single, four or more words dual, else high.
// - Error flag low while error detected, no latching.
// - Multiple error flag low while uncorrectable error detected, no latching.
// - Parity fault low when byte parity disagrees with system data.
// - Reset/select code: 00 reset first, 01 reset second, 10/11 select.
`timescale 1ns/1ps
`default_nettype none
`include "efc_cfg.svh"
// ****************************************
// Synchronous FIFO with runtime limit
// ****************************************
module efc_fifo #(
  parameter int W = 64,
  parameter int DEPTH = `EFC_DEPTH,
  parameter int CW = $clog2(DEPTH) + 1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic [CW-1:0] limit,
  input wire logic inValid,
  output logic inReady,
  input wire logic [W-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [W-1:0] outData,
  output logic [CW-1:0] count
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_r, wp_nxt, rp_r, rp_nxt;
  logic [CW-1:0] cnt_r, cnt_nxt;
  logic push, pop;
  assign inReady = cnt_r < limit;
  assign outValid = cnt_r != '0;
  assign outData = mem[rp_r];
  assign count = cnt_r;
  assign push = inValid & inReady & ~clear;
  assign pop = outValid & outReady & ~clear;
  always_comb begin
    wp_nxt = wp_r;
    rp_nxt = rp_r;
    cnt_nxt = cnt_r;
    if (clear) begin
      wp_nxt = '0;
      rp_nxt = '0;
      cnt_nxt = '0;
    end else begin
      if (push) begin
        wp_nxt = wp_r + AW'(1);
      end
      if (pop) begin
        rp_nxt = rp_r + AW'(1);
      end
      if (push && !pop) begin
        cnt_nxt = cnt_r + CW'(1);
      end else if (pop && !push) begin
        cnt_nxt = cnt_r - CW'(1);
      end
    end
  end
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
      cnt_r <= '0;
    end else begin
      wp_r <= wp_nxt;
      rp_r <= rp_nxt;
      cnt_r <= cnt_nxt;
    end
  end
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_r] <= inData;
    end
  end
endmodule
// ****************************************
// FIFO, mode and diagnostic control
// ****************************************
module efc_ctrl #(
  parameter int DW = 64,
  parameter int DEPTH = `EFC_DEPTH
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic memoryClock,
  input wire logic diagnosticClock,
  input wire logic readPathFifoSelect,
  input wire logic readFifoPushEnableN,
  input wire logic readFifoPopEnableN,
  input wire logic writeFifoPushEnableN,
  input wire logic writeFifoPopEnableN,
  input wire logic checkbitSyndromeOutputForce,
  input wire logic memoryOutputEnableN,
  input wire logic modeLoadN,
  input wire logic [1:0] fifoResetSelect,
  input wire logic [DW-1:0] memData,
  input wire logic [DW-1:0] sysData,
  input wire logic [DW/8-1:0] byteParity,
  input wire logic [DW-1:0] mdOutLatch,
  input wire logic decErr,
  input wire logic decMultiErr,
  input wire logic [7:0] decSyndrome,
  input wire logic [7:0] genCheckBits,
  input wire logic diagReset,
  output logic [DW-1:0] sysReadData,
  output logic [DW-1:0] memWriteData,
  output logic [7:0] checkbitSyndromeOut,
  output logic checkbitSyndromeOe,
  output logic writeFifoEmptyN,
  output logic writeFifoFullN,
  output logic readFifoEmptyN,
  output logic readFifoHalfN,
  output logic readFifoFullN,
  output logic errorFlagN,
  output logic multiFaultFlagN,
  output logic byteParityFaultN,
  output logic [`EFC_MODE_W-1:0] modeReg,
  output logic [3:0] errCount,
  output logic [7:0] firstCheckBits,
  output logic [7:0] firstSyndrome,
  output logic [1:0] firstErrType,
  output logic [DW-1:0] firstErrData,
  output logic [7:0] runSyndrome
);
  localparam int CW = $clog2(DEPTH) + 1;
  localparam int NB = DW / 8;
  localparam int PW = 2 * DW + NB + 12;
  // Idle pin levels at reset
  localparam logic [PW-1:0] SYNC_IDLE = {7'h1F, 3'h3, `EFC_RS_SEL_A, {(2 * DW + NB){1'h0}}};
  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [PW-1:0] s1_r, s2_r;
  logic [1:0] clk3_r;
  logic memClkS, diagClkS, rdSelS, rdPushNS, rdPopNS, wrPushNS, wrPopNS;
  logic forceS, moeNS, modeLoadNS, memRise, diagRise;
  logic [1:0] rsS;
  logic [DW-1:0] memDataS, sysDataS;
  logic [NB-1:0] parS;
  assign {memClkS, diagClkS, rdSelS, rdPushNS, rdPopNS, wrPushNS, wrPopNS, forceS, moeNS, modeLoadNS, rsS,
          memDataS, sysDataS, parS} = s2_r;
  assign memRise = memClkS & ~clk3_r[1];
  assign diagRise = diagClkS & ~clk3_r[0];
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s1_r <= SYNC_IDLE;
      s2_r <= SYNC_IDLE;
      clk3_r <= 2'h0;
    end else begin
      s1_r <= {memoryClock, diagnosticClock, readPathFifoSelect, readFifoPushEnableN, readFifoPopEnableN,
               writeFifoPushEnableN, writeFifoPopEnableN, checkbitSyndromeOutputForce, memoryOutputEnableN,
               modeLoadN, fifoResetSelect, memData, sysData, byteParity};
      s2_r <= s1_r;
      clk3_r <= {memClkS, diagClkS};
    end
  end
  // ****************************************
  // FIFO banks
  // ****************************************
  efc_pkg::efc_bank_t bankSel_r, bankSel_nxt, bankAct;
  logic [`EFC_MODE_W-1:0] modeReg_r, modeReg_nxt;
  logic dual, oddPar, selB, rdPush, rdPop, wrPush, wrPop;
  logic [CW-1:0] lim, halfThr, rdCntSel, wrCntSel;
  logic [CW-1:0] rdCnt [2];
  logic [CW-1:0] wrCnt [2];
  logic [DW-1:0] rdHead [2];
  logic [DW-1:0] wrHead [2];
  logic [1:0] rdVld, wrVld;
  assign dual = modeReg_r[`EFC_DUAL_BIT];
  assign oddPar = modeReg_r[`EFC_ODDPAR_BIT];
  assign bankAct = dual ? bankSel_r : efc_pkg::EFC_BANK_A;
  assign selB = bankAct == efc_pkg::EFC_BANK_B;
  assign lim = dual ? CW'(DEPTH / 2) : CW'(DEPTH);
  assign halfThr = lim >> 1;
  assign rdPush = memRise & ~rdPushNS;
  assign rdPop = ~rdPopNS;
  assign wrPush = ~wrPushNS;
  assign wrPop = memRise & ~wrPopNS;
  assign rdCntSel = selB ? rdCnt[1] : rdCnt[0];
  assign wrCntSel = selB ? wrCnt[1] : wrCnt[0];
  for (genvar b = 0; b < 2; b++) begin : g_bank
    localparam efc_pkg::efc_bank_t BK = (b == 1) ? efc_pkg::EFC_BANK_B : efc_pkg::EFC_BANK_A;
    logic hit, clr;
    assign hit = bankAct == BK;
    assign clr = rsS == ((b == 1) ? `EFC_RS_RST_B : `EFC_RS_RST_A);
    efc_fifo #(.W(DW), .DEPTH(DEPTH), .CW(CW)) u_rd (
      .clk(sys_clk), .rst_n(rst_n), .clear(clr), .limit(lim),
      .inValid(hit & rdPush), .inReady(), .inData(memDataS),
      .outValid(rdVld[b]), .outReady(hit & rdPop), .outData(rdHead[b]), .count(rdCnt[b])
    );
    efc_fifo #(.W(DW), .DEPTH(DEPTH), .CW(CW)) u_wr (
      .clk(sys_clk), .rst_n(rst_n), .clear(clr), .limit(lim),
      .inValid(hit & wrPush), .inReady(), .inData(sysDataS),
      .outValid(wrVld[b]), .outReady(hit & wrPop), .outData(wrHead[b]), .count(wrCnt[b])
    );
  end
  // ****************************************
  // Parity check
  // ****************************************
  logic [NB-1:0] parFault;
  for (genvar i = 0; i < NB; i++) begin : g_par
    assign parFault[i] = (^sysDataS[8*i +: 8]) ^ parS[i] ^ oddPar;
  end
  // ****************************************
  // Control and diagnostic state
  // ****************************************
  logic [3:0] errCnt_r, errCnt_nxt, cntBase;
  logic captured_r, captured_nxt, capBase;
  logic [7:0] firstCb_r, firstCb_nxt, firstSyn_r, firstSyn_nxt, runSyn_r, runSyn_nxt;
  efc_pkg::efc_errtype_t firstType_r, firstType_nxt;
  logic [DW-1:0] firstData_r, firstData_nxt, sysRd_r, sysRd_nxt, memWr_r, memWr_nxt;
  logic [7:0] cbsOut_r, cbsOut_nxt;
  logic cbsOe_r, cbsOe_nxt, wEmptyN_r, wEmptyN_nxt, wFullN_r, wFullN_nxt;
  logic rEmptyN_r, rEmptyN_nxt, rHalfN_r, rHalfN_nxt, rFullN_r, rFullN_nxt;
  logic errN_r, errN_nxt, merrN_r, merrN_nxt, perrN_r, perrN_nxt;
  always_comb begin
    bankSel_nxt = bankSel_r;
    if (rsS == `EFC_RS_SEL_A) begin
      bankSel_nxt = efc_pkg::EFC_BANK_A;
    end else if (rsS == `EFC_RS_SEL_B) begin
      bankSel_nxt = efc_pkg::EFC_BANK_B;
    end
    // mode load, level held through edge
    modeReg_nxt = !modeLoadNS ? sysDataS[`EFC_MODE_W-1:0] : modeReg_r;
    sysRd_nxt = sysRd_r;
    if (!rdSelS) begin
      sysRd_nxt = mdOutLatch;
    end else if (rdPop && (selB ? rdVld[1] : rdVld[0])) begin
      sysRd_nxt = selB ? rdHead[1] : rdHead[0];
    end
    memWr_nxt = memWr_r;
    if (wrPop && (selB ? wrVld[1] : wrVld[0])) begin
      memWr_nxt = selB ? wrHead[1] : wrHead[0];
    end
    cbsOe_nxt = forceS | ~moeNS;
    cbsOut_nxt = moeNS ? decSyndrome : genCheckBits;
    runSyn_nxt = diagRise ? decSyndrome : runSyn_r;
    cntBase = diagReset ? 4'h0 : errCnt_r;
    capBase = diagReset ? 1'b0 : captured_r;
    errCnt_nxt = cntBase;
    captured_nxt = capBase;
    firstCb_nxt = firstCb_r;
    firstSyn_nxt = firstSyn_r;
    firstType_nxt = firstType_r;
    firstData_nxt = firstData_r;
    if (diagRise && decErr) begin
      if (cntBase != `EFC_ERRCNT_MAX) begin
        errCnt_nxt = cntBase + 4'h1;
      end
      if (!capBase) begin
        captured_nxt = 1'b1;
        firstCb_nxt = genCheckBits;
        firstSyn_nxt = decSyndrome;
        firstType_nxt = {decMultiErr, ~decMultiErr};
        firstData_nxt = memDataS;
      end
    end
    wEmptyN_nxt = wrCntSel != '0;
    wFullN_nxt = wrCntSel != lim;
    rEmptyN_nxt = rdCntSel != '0;
    rFullN_nxt = rdCntSel != lim;
    rHalfN_nxt = rdCntSel < halfThr;
    errN_nxt = ~decErr;
    merrN_nxt = ~decMultiErr;
    perrN_nxt = parFault == '0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      bankSel_r <= efc_pkg::EFC_BANK_A;
      modeReg_r <= `EFC_MODE_RST;
      sysRd_r <= '0;
      memWr_r <= '0;
      cbsOe_r <= 1'b0;
      cbsOut_r <= 8'h00;
      runSyn_r <= 8'h00;
      errCnt_r <= 4'h0;
      captured_r <= 1'b0;
      firstCb_r <= 8'h00;
      firstSyn_r <= 8'h00;
      firstType_r <= 2'h0;
      firstData_r <= '0;
      wEmptyN_r <= 1'b0;
      wFullN_r <= 1'b1;
      rEmptyN_r <= 1'b0;
      rFullN_r <= 1'b1;
      rHalfN_r <= 1'b1;
      errN_r <= 1'b1;
      merrN_r <= 1'b1;
      perrN_r <= 1'b1;
    end else begin
      bankSel_r <= bankSel_nxt;
      modeReg_r <= modeReg_nxt;
      sysRd_r <= sysRd_nxt;
      memWr_r <= memWr_nxt;
      cbsOe_r <= cbsOe_nxt;
      cbsOut_r <= cbsOut_nxt;
      runSyn_r <= runSyn_nxt;
      errCnt_r <= errCnt_nxt;
      captured_r <= captured_nxt;
      firstCb_r <= firstCb_nxt;
      firstSyn_r <= firstSyn_nxt;
      firstType_r <= firstType_nxt;
      firstData_r <= firstData_nxt;
      wEmptyN_r <= wEmptyN_nxt;
      wFullN_r <= wFullN_nxt;
      rEmptyN_r <= rEmptyN_nxt;
      rFullN_r <= rFullN_nxt;
      rHalfN_r <= rHalfN_nxt;
      errN_r <= errN_nxt;
      merrN_r <= merrN_nxt;
      perrN_r <= perrN_nxt;
    end
  end
  assign sysReadData = sysRd_r;
  assign memWriteData = memWr_r;
  assign checkbitSyndromeOut = cbsOut_r;
  assign checkbitSyndromeOe = cbsOe_r;
  assign writeFifoEmptyN = wEmptyN_r;
  assign writeFifoFullN = wFullN_r;
  assign readFifoEmptyN = rEmptyN_r;
  assign readFifoHalfN = rHalfN_r;
  assign readFifoFullN = rFullN_r;
  assign errorFlagN = errN_r;
  assign multiFaultFlagN = merrN_r;
  assign byteParityFaultN = perrN_r;
  assign modeReg = modeReg_r;
  assign errCount = errCnt_r;
  assign firstCheckBits = firstCb_r;
  assign firstSyndrome = firstSyn_r;
  assign firstErrType = firstType_r;
  assign firstErrData = firstData_r;
  assign runSyndrome = runSyn_r;
  // ****************************************
  // Assertions
  // ****************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  logic steady;
  assign steady = modeLoadNS && rsS == (selB ? `EFC_RS_SEL_B : `EFC_RS_SEL_A);
  AST_READ_PATH: assert property (!rdSelS |=> sysReadData == $past(mdOutLatch))
    else $error("latch path not selected");
  AST_RD_PUSH: assert property (steady && rdPush && !rdPop && rdCntSel < lim |=>
    rdCntSel == $past(rdCntSel) + CW'(1)) else $error("read FIFO push lost");
  AST_RD_POP: assert property (steady && !rdPush && rdPop && rdCntSel != '0 |=>
    rdCntSel == $past(rdCntSel) - CW'(1)) else $error("read FIFO pop lost");
  AST_WR_POP: assert property (steady && wrPop && !wrPush && wrCntSel != '0 |=>
    wrCntSel == $past(wrCntSel) - CW'(1) && memWriteData == $past(selB ? wrHead[1] : wrHead[0]))
    else $error("write FIFO pop wrong");
  AST_WR_PUSH: assert property (steady && wrPush && !wrPop && wrCntSel < lim |=>
    wrCntSel == $past(wrCntSel) + CW'(1)) else $error("write FIFO push lost");
  AST_CBS_OE: assert property (forceS || !moeNS |=> checkbitSyndromeOe ##0 1)
    else $error("driver not enabled");
  AST_CBS_OFF: assert property (!forceS && moeNS |=> !checkbitSyndromeOe)
    else $error("driver enabled without cause");
  AST_MODE_LOAD: assert property (!modeLoadNS |=> modeReg == $past(sysDataS[15:0]))
    else $error("mode register not loaded");
  AST_ERR_COUNT: assert property (diagRise && decErr && !diagReset && errCount != 4'hF |=>
    errCount == $past(errCount) + 4'h1) else $error("error count missed");
  AST_ERR_SAT: assert property (errCount == 4'hF && !diagReset |=> errCount == 4'hF)
    else $error("error count wrapped");
  AST_FIRST_KEEP: assert property (captured_r && !diagReset |=> $stable(firstErrData) &&
    $stable(firstSyndrome)) else $error("first error overwritten");
  AST_RUN_SYN: assert property (diagRise |=> runSyndrome == $past(decSyndrome))
    else $error("running syndrome stale");
  AST_WR_FLAGS: assert property (wrCntSel == '0 |=> !writeFifoEmptyN && writeFifoFullN)
    else $error("write empty flag wrong");
  AST_WR_FULL: assert property (wrCntSel == lim |=> !writeFifoFullN)
    else $error("write full flag wrong");
  AST_RD_EMPTY: assert property (rdCntSel == '0 |=> !readFifoEmptyN)
    else $error("read empty flag wrong");
  AST_RD_FULL: assert property (rdCntSel == lim |=> !readFifoFullN && !readFifoHalfN)
    else $error("read full flag wrong");
  AST_RD_HALF: assert property (rdCntSel < halfThr |=> readFifoHalfN)
    else $error("half flag low too early");
  AST_ERR_FLAG: assert property (decErr ##1 !decErr |=> errorFlagN)
    else $error("error flag held");
  AST_MULTI_FAULT_FLAG_N_FLAG: assert property (decMultiErr |=> !multiFaultFlagN)
    else $error("multiple error flag missed");
  AST_PARITY: assert property (parFault != '0 |=> !byteParityFaultN)
    else $error("parity fault missed");
  AST_RS_RESET: assert property (rsS == `EFC_RS_RST_A |=> rdCnt[0] == '0 && wrCnt[0] == '0)
    else $error("first bank not reset");
  AST_FULL_HOLD: assert property (steady && rdPush && !rdPop && rdCntSel == lim |=>
    rdCntSel == $past(rdCntSel)) else $error("push into full changed count");
endmodule
`default_nettype wire

// [logic/efc_cfg.svh]
`ifndef EFC_CFG_SVH
`define EFC_CFG_SVH
// ****************************************
// Depths and mode fields
// ****************************************
`define EFC_DEPTH 16
`define EFC_MODE_W 16
`define EFC_MODE_RST 16'h0000
`define EFC_DUAL_BIT 0
`define EFC_ODDPAR_BIT 1
`define EFC_ERRCNT_MAX 4'hF
// ****************************************
// Reset and select codes
// ****************************************
`define EFC_RS_RST_A 2'h0
`define EFC_RS_RST_B 2'h1
`define EFC_RS_SEL_A 2'h2
`define EFC_RS_SEL_B 2'h3
`endif

// [logic/efc_pkg.sv]
`default_nettype none
package efc_pkg;
  typedef enum logic {EFC_BANK_A, EFC_BANK_B} efc_bank_t;
  typedef logic [1:0] efc_errtype_t;
endpackage
`default_nettype wire

// [testbench/efc_mem_model.sv]
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// Memory side clocks and data
// ****************************************
module efc_mem_model #(
  parameter int DW = 64
) (
  input wire logic sys_clk,
  output logic memoryClock,
  output logic diagnosticClock,
  output logic readFifoPushEnableN,
  output logic writeFifoPopEnableN,
  output logic [DW-1:0] memData
);
  initial begin
    memoryClock = 1'h0;
    diagnosticClock = 1'h0;
    readFifoPushEnableN = 1'h1;
    writeFifoPopEnableN = 1'h1;
    memData = '0;
  end

  task automatic pulse(input logic rd, input logic wr, input logic dg, input logic [DW-1:0] w);
    @(posedge sys_clk);
    memData <= w;
    readFifoPushEnableN <= ~rd;
    writeFifoPopEnableN <= ~wr;
    memoryClock <= ~dg;
    diagnosticClock <= dg;
    repeat (2) @(posedge sys_clk);
    memoryClock <= 1'h0;
    diagnosticClock <= 1'h0;
    @(posedge sys_clk);
    // Released bus shows inverted word
    memData <= ~w;
    readFifoPushEnableN <= 1'h1;
    writeFifoPopEnableN <= 1'h1;
    @(posedge sys_clk);
  endtask
endmodule
`default_nettype wire

// [testbench/test_ecc_fifo_diag_control.sv]
`timescale 1ns/1ps
`default_nettype none
module test_ecc_fifo_diag_control;
  localparam int DW = 64;
  logic sys_clk = 1'h0;
  logic rst_n = 1'h0;
  logic readPathFifoSelect = 1'h1;
  logic readFifoPopEnableN = 1'h1;
  logic writeFifoPushEnableN = 1'h1;
  logic checkbitSyndromeOutputForce = 1'h0;
  logic memoryOutputEnableN = 1'h1;
  logic modeLoadN = 1'h1;
  logic decErr = 1'h0;
  logic decMultiErr = 1'h0;
  logic diagReset = 1'h0;
  logic [1:0] fifoResetSelect = 2'h2;
  logic [7:0] decSyndrome = 8'h00;
  logic [7:0] genCheckBits = 8'h00;
  logic [7:0] byteParity = 8'h00;
  logic [DW-1:0] sysData = 64'h0;
  logic [DW-1:0] mdOutLatch = 64'h0;
  wire logic memoryClock;
  wire logic diagnosticClock;
  wire logic readFifoPushEnableN;
  wire logic writeFifoPopEnableN;
  wire logic [DW-1:0] memData;
  logic [DW-1:0] sysReadData, memWriteData, firstErrData;
  logic [7:0] checkbitSyndromeOut, firstCheckBits, firstSyndrome, runSyndrome;
  logic [15:0] modeReg;
  logic [3:0] errCount;
  logic [1:0] firstErrType;
  logic checkbitSyndromeOe, writeFifoEmptyN, writeFifoFullN, readFifoEmptyN, readFifoHalfN, readFifoFullN;
  logic errorFlagN, multiFaultFlagN, byteParityFaultN;
  int miscompares = 0;
  int cmp_count = 0;

  always #25 sys_clk = ~sys_clk;

  efc_ctrl #(.DW(DW), .DEPTH(16)) i_dut (
    .sys_clk, .rst_n, .memoryClock, .diagnosticClock, .readPathFifoSelect, .readFifoPushEnableN,
    .readFifoPopEnableN, .writeFifoPushEnableN, .writeFifoPopEnableN, .checkbitSyndromeOutputForce,
    .memoryOutputEnableN, .modeLoadN, .fifoResetSelect, .memData, .sysData, .byteParity, .mdOutLatch,
    .decErr, .decMultiErr, .decSyndrome, .genCheckBits, .diagReset, .sysReadData, .memWriteData,
    .checkbitSyndromeOut, .checkbitSyndromeOe, .writeFifoEmptyN, .writeFifoFullN, .readFifoEmptyN,
    .readFifoHalfN, .readFifoFullN, .errorFlagN, .multiFaultFlagN, .byteParityFaultN, .modeReg,
    .errCount, .firstCheckBits, .firstSyndrome, .firstErrType, .firstErrData, .runSyndrome
  );

  efc_mem_model #(.DW(DW)) i_mem (
    .sys_clk, .memoryClock, .diagnosticClock, .readFifoPushEnableN, .writeFifoPopEnableN, .memData
  );

  // ****************************************
  // Compare and closing tasks
  // ****************************************
  task automatic chk_word(input logic [DW-1:0] got, input logic [DW-1:0] exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chk_flag(input logic got, input logic exp);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic wt(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic set_rs(input logic [1:0] c);
    @(posedge sys_clk);
    fifoResetSelect <= c;
    wt(6);
  endtask

  task automatic load_mode(input logic [15:0] m);
    @(posedge sys_clk);
    sysData <= {48'hFFFF_0000_FFFF, m};
    modeLoadN <= 1'h0;
    @(posedge sys_clk);
    modeLoadN <= 1'h1;
    wt(5);
    chk_word(64'(modeReg), 64'(m));
  endtask

  // ****************************************
  // Scenarios
  // ****************************************
  task automatic read_single;
    int i;
    for (i = 0; i < 17; i++) begin
      i_mem.pulse(1'h1, 1'h0, 1'h0, 64'hC0DE_0000_0000_0000 + 64'(i));
      wt(3);
      if (i == 6 || i == 7) chk_flag(readFifoHalfN, 1'(i == 6));
    end
    chk_flag(readFifoFullN, 1'h0);
    chk_flag(readFifoEmptyN, 1'h1);
    for (i = 0; i < 17; i++) begin
      @(posedge sys_clk);
      readFifoPopEnableN <= 1'h0;
      @(posedge sys_clk);
      readFifoPopEnableN <= 1'h1;
      wt(5);
      chk_word(sysReadData, 64'hC0DE_0000_0000_0000 + 64'(i < 16 ? i : 15));
    end
    chk_flag(readFifoEmptyN, 1'h0);
    @(posedge sys_clk);
    readPathFifoSelect <= 1'h0;
    mdOutLatch <= 64'h0123_4567_89AB_CDEF;
    wt(6);
    chk_word(sysReadData, 64'h0123_4567_89AB_CDEF);
    @(posedge sys_clk);
    readPathFifoSelect <= 1'h1;
  endtask

  task automatic read_dual;
    int i;
    load_mode(16'h0001);
    for (i = 0; i < 8; i++) begin
      i_mem.pulse(1'h1, 1'h0, 1'h0, 64'h5 + 64'(i));
      wt(3);
      if (i == 2 || i == 3) chk_flag(readFifoHalfN, 1'(i == 2));
    end
    chk_flag(readFifoFullN, 1'h0);
    set_rs(2'h3);
    chk_flag(readFifoEmptyN, 1'h0);
    i_mem.pulse(1'h1, 1'h0, 1'h0, 64'h9);
    wt(3);
    chk_flag(readFifoEmptyN, 1'h1);
    set_rs(2'h1);
    set_rs(2'h3);
    chk_flag(readFifoEmptyN, 1'h0);
    set_rs(2'h2);
    chk_flag(readFifoFullN, 1'h0);
    set_rs(2'h0);
    set_rs(2'h2);
    chk_flag(readFifoEmptyN, 1'h0);
    chk_flag(readFifoFullN, 1'h1);
    load_mode(16'h0000);
  endtask

  task automatic write_path;
    int i;
    for (i = 0; i < 17; i++) begin
      @(posedge sys_clk);
      sysData <= 64'hA000_0000_0000_0000 + 64'(i);
      writeFifoPushEnableN <= 1'h0;
    end
    @(posedge sys_clk);
    writeFifoPushEnableN <= 1'h1;
    wt(6);
    chk_flag(writeFifoFullN, 1'h0);
    chk_flag(writeFifoEmptyN, 1'h1);
    for (i = 0; i < 16; i++) begin
      i_mem.pulse(1'h0, 1'h1, 1'h0, 64'h0);
      wt(2);
      chk_word(memWriteData, 64'hA000_0000_0000_0000 + 64'(i));
    end
    wt(3);
    chk_flag(writeFifoEmptyN, 1'h0);
    chk_flag(writeFifoFullN, 1'h1);
  endtask

  task automatic diag;
    int i;
    @(posedge sys_clk);
    diagReset <= 1'h1;
    @(posedge sys_clk);
    diagReset <= 1'h0;
    decErr <= 1'h1;
    for (i = 0; i < 16; i++) begin
      @(posedge sys_clk);
      decSyndrome <= 8'h5A + 8'(i);
      genCheckBits <= 8'h3C + 8'(i);
      i_mem.pulse(1'h0, 1'h0, 1'h1, 64'hDEAD_BEEF_0000_1111 + 64'(i));
      wt(2);
      chk_word(64'(errCount), 64'(i < 15 ? i + 1 : 15));
      chk_word(64'(runSyndrome), 64'h5A + 64'(i));
      chk_word(firstErrData, 64'hDEAD_BEEF_0000_1111);
    end
    chk_word(64'(firstSyndrome), 64'h5A);
    chk_word(64'(firstCheckBits), 64'h3C);
    chk_word(64'(firstErrType), 64'h1);
    @(posedge sys_clk);
    decErr <= 1'h0;
    decSyndrome <= 8'h77;
    i_mem.pulse(1'h0, 1'h0, 1'h1, 64'h0);
    wt(2);
    chk_word(64'(runSyndrome), 64'h77);
    chk_word(64'(errCount), 64'hF);
  endtask

  task automatic flags_and_driver;
    int i;
    for (i = 3; i >= 0; i--) begin
      @(posedge sys_clk);
      decErr <= i[0] | i[1];
      decMultiErr <= i[1];
      checkbitSyndromeOutputForce <= i[0];
      memoryOutputEnableN <= i[1];
      decSyndrome <= 8'h81;
      genCheckBits <= 8'h42;
      wt(4);
      chk_flag(errorFlagN, ~(i[0] | i[1]));
      chk_flag(multiFaultFlagN, ~i[1]);
      chk_flag(checkbitSyndromeOe, i[0] | ~i[1]);
      if (i != 2) chk_word(64'(checkbitSyndromeOut), i[1] ? 64'h81 : 64'h42);
    end
  endtask

  task automatic parity;
    int i;
    logic [7:0] par [3] = '{8'h01, 8'h03, 8'hFE};
    for (i = 0; i < 3; i++) begin
      if (i == 2) load_mode(16'h0002);
      @(posedge sys_clk);
      sysData <= 64'h0301;
      byteParity <= par[i];
      wt(6);
      chk_flag(byteParityFaultN, 1'(i != 1));
    end
    load_mode(16'h0000);
  endtask

  initial begin
    repeat (20000) @(posedge sys_clk);
    miscompares++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge sys_clk);
    rst_n <= 1'h1;
    wt(1);
    chk_flag(writeFifoEmptyN, 1'h0);
    chk_flag(writeFifoFullN, 1'h1);
    chk_flag(readFifoEmptyN, 1'h0);
    chk_flag(readFifoFullN, 1'h1);
    chk_flag(readFifoHalfN, 1'h1);
    load_mode(16'hA5C0);
    load_mode(16'h0000);
    read_single();
    read_dual();
    write_path();
    diag();
    flags_and_driver();
    parity();
    tally_and_finish();
  end
endmodule
`default_nettype wire
